// >>> pkg/pin_select_pkg.sv
package pin_select_pkg;
   localparam logic [11:0] sel_8_9_offset = 12'h000;
   localparam logic [11:0] sel_10_11_offset = 12'h004;
   localparam logic [11:0] mismatch_offset = 12'h008;
   localparam int code_width = 5;
   localparam int hi_field_lsb = 8;
   localparam int lo_field_lsb = 0;
   localparam logic [4:0] code_reset = 5'h00;
   localparam logic [4:0] code_port_logic = 5'h00;
   localparam int num_functions = 32;
   localparam int num_pins = 4;
endpackage : pin_select_pkg

// >>> logic/function_crossbar.sv
`timescale 1ns/1ps
`default_nettype none
module function_crossbar (
   // selection code
   input wire logic [4:0] code,
   // port logic fallback
   input wire logic port_data,
   input wire logic port_enable,
   // peripheral outputs indexed by code
   input wire logic [31:0] periph_data,
   input wire logic [31:0] periph_enable,
   // pad side
   output logic pad_data,
   output logic pad_enable
);
   wire logic is_port = (code == pin_select_pkg::code_port_logic);
   assign pad_data = is_port ? port_data : periph_data[code];
   assign pad_enable = is_port ? port_enable : periph_enable[code];
endmodule : function_crossbar
`default_nettype wire

// >>> logic/output_pin_function_select.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - The first register holds pin 9 code in bits 12:8 and pin 8 code in bits 4:0.
// - Bits 12:8 of the second register choose the function driving pin 11.
// - Bits 4:0 of the second register choose the function driving pin 10.
// - Bits 15:13 and 7:5 of both registers read zero and ignore writes.
// - A parameter removes the pin 10 and 11 codes, reading zero.
// - A shadow copy is compared continuously and a mismatch requests reset.
module output_pin_function_select #(
   parameter bit has_pins_10_11 = 1'b1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // ordinary port logic, one bit per pin 8..11
   input wire logic [3:0] port_data,
   input wire logic [3:0] port_enable,
   // peripheral outputs indexed by function code
   input wire logic [31:0] periph_data,
   input wire logic [31:0] periph_enable,
   // pads 8..11
   output logic [3:0] pad_data,
   output logic [3:0] pad_enable,
   // configuration mismatch
   output logic config_mismatch_reset,
   output logic config_mismatch_flag
);
   logic [4:0] pin8_function_code;
   logic [4:0] pin9_function_code;
   logic [4:0] pin10_function_code;
   logic [4:0] pin11_function_code;
   logic [19:0] shadow;
   logic [3:0] pad_data_comb;
   logic [3:0] pad_enable_comb;

   function automatic logic [15:0] pack_pair(input logic [4:0] hi,
                                             input logic [4:0] lo);
      pack_pair = {3'b000, hi, 3'b000, lo};
   endfunction : pack_pair

   wire logic access = psel && penable;
   wire logic wr = access && pwrite;
   wire logic hit_a = (paddr == pin_select_pkg::sel_8_9_offset);
   wire logic hit_b = (paddr == pin_select_pkg::sel_10_11_offset);
   wire logic hit_m = (paddr == pin_select_pkg::mismatch_offset);
   wire logic mapped = hit_a || hit_b || hit_m;
   wire logic [4:0] w_hi = pwdata[pin_select_pkg::hi_field_lsb +: 5];
   wire logic [4:0] w_lo = pwdata[pin_select_pkg::lo_field_lsb +: 5];
   wire logic [19:0] live = {pin11_function_code, pin10_function_code,
                             pin9_function_code, pin8_function_code};
   wire logic mismatch = (live != shadow);
   wire logic [15:0] rd_a = pack_pair(pin9_function_code, pin8_function_code);
   wire logic [15:0] rd_b = pack_pair(pin11_function_code,
                                      pin10_function_code);
   wire logic [31:0] rd_mux = hit_a ? {16'h0000, rd_a} :
                              hit_b ? {16'h0000, rd_b} :
                              hit_m ? {31'h0000_0000, config_mismatch_flag} :
                              32'h0000_0000;

   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   // live registers and their shadow are written together
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin8_function_code <= pin_select_pkg::code_reset;
         pin9_function_code <= pin_select_pkg::code_reset;
         pin10_function_code <= pin_select_pkg::code_reset;
         pin11_function_code <= pin_select_pkg::code_reset;
         shadow <= 20'h0_0000;
      end else if (wr && hit_a) begin
         pin9_function_code <= w_hi;
         pin8_function_code <= w_lo;
         shadow[9:0] <= {w_hi, w_lo};
      end else if (wr && hit_b && has_pins_10_11) begin
         pin11_function_code <= w_hi;
         pin10_function_code <= w_lo;
         shadow[19:10] <= {w_hi, w_lo};
      end
   end

   // flag is sticky until software writes one to it; set wins over clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         config_mismatch_flag <= 1'b0;
         config_mismatch_reset <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         config_mismatch_reset <= mismatch;
         if (mismatch) begin
            config_mismatch_flag <= 1'b1;
         end else if (wr && hit_m && pwdata[0]) begin
            config_mismatch_flag <= 1'b0;
         end
         if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_pin
         logic [4:0] code;
         if (g == 0) begin : g0
            assign code = pin8_function_code;
         end else if (g == 1) begin : g1
            assign code = pin9_function_code;
         end else if (g == 2) begin : g2
            assign code = has_pins_10_11 ? pin10_function_code : 5'h00;
         end else begin : g3
            assign code = has_pins_10_11 ? pin11_function_code : 5'h00;
         end
         function_crossbar u_xbar (
            .code(code),
            .port_data(port_data[g]),
            .port_enable(port_enable[g]),
            .periph_data(periph_data),
            .periph_enable(periph_enable),
            .pad_data(pad_data_comb[g]),
            .pad_enable(pad_enable_comb[g])
         );
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (rst) begin
         pad_data <= 4'h0;
         pad_enable <= 4'h0;
      end else begin
         pad_data <= pad_data_comb;
         pad_enable <= pad_enable_comb;
      end
   end

   // bus steps as named sequences
   sequence s_read_setup;
      psel && !penable && !pwrite;
   endsequence : s_read_setup

   sequence s_write_a;
      wr && hit_a;
   endsequence : s_write_a

   sequence s_write_b;
      wr && hit_b && has_pins_10_11;
   endsequence : s_write_b

   sequence s_flag_clear;
      wr && hit_m && pwdata[0] && !mismatch;
   endsequence : s_flag_clear

   AST_RD_ZERO_GAPS: assert property (@(posedge mclk) disable iff (rst)
      (prdata[31:13] == 19'h0_0000) && (prdata[7:5] == 3'b000))
      else $error("reserved read bits not zero");

   AST_WRITE_A: assert property (@(posedge mclk) disable iff (rst)
      s_write_a |=> (pin9_function_code == $past(pwdata[12:8]))
         && (pin8_function_code == $past(pwdata[4:0])))
      else $error("pin 8/9 code not written");

   AST_WRITE_B_HI: assert property (@(posedge mclk) disable iff (rst)
      s_write_b |=> (pin11_function_code == $past(pwdata[12:8])))
      else $error("pin 11 code not written");

   AST_WRITE_B_LO: assert property (@(posedge mclk) disable iff (rst)
      s_write_b |=> (pin10_function_code == $past(pwdata[4:0])))
      else $error("pin 10 code not written");

   AST_SMALL_VARIANT: assert property (@(posedge mclk) disable iff (rst)
      !has_pins_10_11 |-> (pin10_function_code == 5'h00)
         && (pin11_function_code == 5'h00))
      else $error("absent selectors not zero");

   AST_MISMATCH_FLAG: assert property (@(posedge mclk) disable iff (rst)
      mismatch |=> config_mismatch_reset && config_mismatch_flag)
      else $error("mismatch not reported");

   AST_NO_SPURIOUS: assert property (@(posedge mclk) disable iff (rst)
      (!mismatch ##1 1'b1) |-> !config_mismatch_reset)
      else $error("spurious mismatch reset");

   AST_PORT_DEFAULT: assert property (@(posedge mclk) disable iff (rst)
      (pin8_function_code == 5'h00) |=>
         (pad_data[0] == $past(port_data[0])))
      else $error("code zero does not pass port logic");

   AST_PERIPH_SEL: assert property (@(posedge mclk) disable iff (rst)
      (pin9_function_code != 5'h00) |=>
         (pad_enable[1] == $past(periph_enable[pin9_function_code])))
      else $error("peripheral enable not routed");

   AST_PREADY_HIGH: assert property (@(posedge mclk) disable iff (rst)
      pready == 1'b1)
      else $error("wait state inserted");

   AST_SLVERR_UNMAPPED: assert property (@(posedge mclk) disable iff (rst)
      (access && !mapped) |-> pslverr)
      else $error("unmapped access not flagged");

   AST_SLVERR_MAPPED: assert property (@(posedge mclk) disable iff (rst)
      (access && mapped) |-> !pslverr)
      else $error("mapped access flagged");

   AST_READ_LOAD: assert property (@(posedge mclk) disable iff (rst)
      s_read_setup |=> (prdata == $past(rd_mux)))
      else $error("read data not loaded");

   AST_READ_HOLD: assert property (@(posedge mclk) disable iff (rst)
      !(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved without setup");

   AST_HOLD_A: assert property (@(posedge mclk) disable iff (rst)
      !(wr && hit_a) |=> $stable(pin8_function_code)
         && $stable(pin9_function_code))
      else $error("pin 8/9 code changed without write");

   AST_HOLD_B_HI: assert property (@(posedge mclk) disable iff (rst)
      !(wr && hit_b) |=> $stable(pin11_function_code))
      else $error("pin 11 code changed without write");

   AST_HOLD_B_LO: assert property (@(posedge mclk) disable iff (rst)
      !(wr && hit_b) |=> $stable(pin10_function_code))
      else $error("pin 10 code changed without write");

   AST_SMALL_READ: assert property (@(posedge mclk) disable iff (rst)
      (!has_pins_10_11 && hit_b && s_read_setup) |=>
         (prdata == 32'h0000_0000))
      else $error("absent selectors read nonzero");

   AST_SMALL_PADS: assert property (@(posedge mclk) disable iff (rst)
      !has_pins_10_11 |=> (pad_data[3:2] == $past(port_data[3:2]))
         && (pad_enable[3:2] == $past(port_enable[3:2])))
      else $error("absent selectors drive pads");

   AST_SHADOW_A: assert property (@(posedge mclk) disable iff (rst)
      s_write_a |=> (shadow[9:0] == {pin9_function_code,
                                     pin8_function_code}))
      else $error("shadow of pins 8/9 not updated");

   AST_SHADOW_B: assert property (@(posedge mclk) disable iff (rst)
      s_write_b |=> (shadow[19:10] == {pin11_function_code,
                                       pin10_function_code}))
      else $error("shadow of pins 10/11 not updated");

   AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (rst)
      (config_mismatch_flag && !(wr && hit_m && pwdata[0])) |=>
         config_mismatch_flag)
      else $error("mismatch flag lost");

   AST_FLAG_CLEAR: assert property (@(posedge mclk) disable iff (rst)
      s_flag_clear |=> !config_mismatch_flag)
      else $error("mismatch flag not cleared");

   AST_PIN8_ENABLE: assert property (@(posedge mclk) disable iff (rst)
      (pin8_function_code == 5'h00) |=>
         (pad_enable[0] == $past(port_enable[0])))
      else $error("code zero does not pass port enable");

   AST_PIN8_PERIPH: assert property (@(posedge mclk) disable iff (rst)
      (pin8_function_code != 5'h00) |=>
         (pad_data[0] == $past(periph_data[pin8_function_code])))
      else $error("pin 8 peripheral data not routed");

   AST_PIN9_PORT: assert property (@(posedge mclk) disable iff (rst)
      (pin9_function_code == 5'h00) |=>
         (pad_data[1] == $past(port_data[1])))
      else $error("pin 9 port data not passed");

   AST_PIN10_PERIPH: assert property (@(posedge mclk) disable iff (rst)
      (has_pins_10_11 && pin10_function_code != 5'h00) |=>
         (pad_data[2] == $past(periph_data[pin10_function_code])))
      else $error("pin 10 peripheral data not routed");

   AST_PIN11_PERIPH: assert property (@(posedge mclk) disable iff (rst)
      (has_pins_10_11 && pin11_function_code != 5'h00) |=>
         (pad_enable[3] == $past(periph_enable[pin11_function_code])))
      else $error("pin 11 peripheral enable not routed");

   AST_PIN11_PORT: assert property (@(posedge mclk) disable iff (rst)
      (pin11_function_code == 5'h00) |=>
         (pad_data[3] == $past(port_data[3])))
      else $error("pin 11 port data not passed");

   // no disable here: the reset itself is what is checked
   AST_RESET_CLEAR: assert property (@(posedge mclk)
      rst |=> (pin8_function_code == 5'h00) && (pin9_function_code == 5'h00)
         && (pin10_function_code == 5'h00)
         && (pin11_function_code == 5'h00) && !config_mismatch_flag)
      else $error("reset did not clear selectors");
endmodule : output_pin_function_select
`default_nettype wire

// >>> bench/output_pin_function_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module output_pin_function_select_tb_top;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] port_data = 4'h5;
   logic [3:0] port_enable = 4'h3;
   logic [31:0] periph_data = 32'h8000_0002;
   logic [31:0] periph_enable = 32'h0001_0002;
   logic [31:0] prdata, prdata_b, rd, rd_b;
   logic pready, pslverr, err_seen, mm_reset, mm_flag;
   logic [3:0] pad_data, pad_enable, pad_data_b, pad_enable_b;
   logic [4:0] codes [4];
   int err_total = 0;
   int num_checks = 0;
   output_pin_function_select dut (.mclk(mclk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_data(port_data), .port_enable(port_enable),
      .periph_data(periph_data), .periph_enable(periph_enable),
      .pad_data(pad_data), .pad_enable(pad_enable),
      .config_mismatch_reset(mm_reset), .config_mismatch_flag(mm_flag));
   // small variant shares the bus, answers in the same cycle
   output_pin_function_select #(.has_pins_10_11(1'b0)) dut_small (
      .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_b),
      .pready(), .pslverr(), .port_data(port_data),
      .port_enable(port_enable), .periph_data(periph_data),
      .periph_enable(periph_enable), .pad_data(pad_data_b),
      .pad_enable(pad_enable_b), .config_mismatch_reset(),
      .config_mismatch_flag());
   initial forever #5 mclk = ~mclk;
   task check(input string what, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         summarize();
      end
      rd = prdata;
      rd_b = prdata_b;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic pick(input logic [4:0] c, input logic p,
                                 input logic [31:0] v);
      return (c == 5'h00) ? p : v[c];
   endfunction : pick
   // fixed wait: pads follow one cycle after their inputs
   task check_pads;
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 4; i++) begin
         check("pad_data", 32'(pad_data[i]),
               32'(pick(codes[i], port_data[i], periph_data)));
         check("pad_enable", 32'(pad_enable[i]),
               32'(pick(codes[i], port_enable[i], periph_enable)));
      end
      check("small pads", 32'(pad_data_b[3:2]), 32'(port_data[3:2]));
      check("small en", 32'(pad_enable_b[3:2]), 32'(port_enable[3:2]));
   endtask : check_pads
   initial begin
      codes = '{default: 5'h00};
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, pin_select_pkg::sel_8_9_offset, 32'h0000_0000);
      check("reset 8_9", rd, 32'h0000_0000);
      apb(1'b0, pin_select_pkg::sel_10_11_offset, 32'h0000_0000);
      check("reset 10_11", rd, 32'h0000_0000);
      check_pads();
      apb(1'b1, pin_select_pkg::sel_8_9_offset, 32'hFFFF_FFE0);
      apb(1'b1, pin_select_pkg::sel_10_11_offset, 32'h0000_F0E1);
      apb(1'b0, pin_select_pkg::sel_8_9_offset, 32'h0000_0000);
      check("sel_8_9", rd, 32'h0000_1F00);
      apb(1'b0, pin_select_pkg::sel_10_11_offset, 32'h0000_0000);
      check("sel_10_11", rd, 32'h0000_1001);
      check("small 10_11", rd_b, 32'h0000_0000);
      codes = '{5'h00, 5'h1F, 5'h01, 5'h10};
      check_pads();
      port_data <= 4'hA;
      periph_data <= 32'h0001_0000;
      periph_enable <= 32'h8000_0001;
      check_pads();
      apb(1'b1, 12'h00C, 32'h0000_FFFF);
      check("unmapped err", 32'(err_seen), 32'h0000_0001);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      check("unmapped rd", rd, 32'h0000_0000);
      apb(1'b0, pin_select_pkg::sel_8_9_offset, 32'h0000_0000);
      check("after unmapped", rd, 32'h0000_1F00);
      check("mismatch", 32'({mm_flag, mm_reset}), 32'h0000_0000);
      apb(1'b1, pin_select_pkg::mismatch_offset, 32'h0000_0001);
      check("flag err", 32'(err_seen), 32'h0000_0000);
      apb(1'b0, pin_select_pkg::mismatch_offset, 32'h0000_0000);
      check("flag rd", rd, 32'h0000_0000);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      codes = '{default: 5'h00};
      apb(1'b0, pin_select_pkg::sel_10_11_offset, 32'h0000_0000);
      check("rereset", rd, 32'h0000_0000);
      check_pads();
      summarize();
   end
endmodule : output_pin_function_select_tb_top
`default_nettype wire
